// ==== fqf_defs.svh ====
// Constants for the four-queue flag, echo and power-down block
`ifndef FQF_DEFS_SVH
`define FQF_DEFS_SVH

// ----------------------------------------------------------------------------
// Widths and geometry
// ----------------------------------------------------------------------------
`define FQF_WORD_W 40
`define FQF_HALF_W 10
`define FQF_QUEUES 4
`define FQF_DEPTH 16
`define FQF_PTR_W 5
`define FQF_ADDR_W 6
`define FQF_QSEL_W 2

// ----------------------------------------------------------------------------
// Bus width select encodings
// ----------------------------------------------------------------------------
`define FQF_BW_X40 2'h0
`define FQF_BW_X20 2'h1
`define FQF_BW_X10 2'h2

// ----------------------------------------------------------------------------
// Flag offsets: eight offsets of 13 bits, almost-empty then almost-full per queue
// ----------------------------------------------------------------------------
`define FQF_OFS_W 13
`define FQF_OFS_BITS 104
`define FQF_OFS_RST 104'h0
`define FQF_AE_RST 4'h0
`define FQF_AF_RST 4'hF

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define FQF_CLK_NS 10
`define FQF_WAKE_NS 1000
`define FQF_WAKE_CYC ((`FQF_WAKE_NS + `FQF_CLK_NS - 1) / `FQF_CLK_NS)
`define FQF_CNT_W 7

`endif

// ==== fqf_pkg.sv ====
// Types shared by the four-queue flag block
`include "fqf_defs.svh"

package fqf_pkg;
  typedef logic [`FQF_WORD_W-1:0] fqf_word_t;
  typedef logic [`FQF_PTR_W-1:0] fqf_ptr_t;
  typedef logic [`FQF_ADDR_W-1:0] fqf_addr_t;
  typedef logic [`FQF_QSEL_W-1:0] fqf_qsel_t;
  typedef logic [`FQF_OFS_W-1:0] fqf_ofs_t;
  typedef enum logic [1:0] {FQF_PD_RUN, FQF_PD_DOWN, FQF_PD_WAKE} fqf_pd_state_t;
endpackage : fqf_pkg

// ==== fqf_mem_if.sv ====
// Interface between the queue control logic and the queue storage
`timescale 1ns/1ps
`default_nettype none

interface fqf_mem_if;
  import fqf_pkg::*;
  logic wr_en;
  fqf_addr_t wr_addr;
  fqf_word_t wr_data;
  logic rd_en;
  fqf_addr_t rd_addr;
  fqf_word_t rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_en, output rd_addr,
                input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_en, input rd_addr,
               output rd_data);
endinterface : fqf_mem_if

`default_nettype wire

// ==== fqf_ram.sv ====
// Storage for all four queues, one write port, registered read port
`timescale 1ns/1ps
`default_nettype none
`include "fqf_defs.svh"

module fqf_ram
  import fqf_pkg::*;
(
  input wire logic clock,
  fqf_mem_if.mem port
);
  fqf_word_t store [`FQF_QUEUES*`FQF_DEPTH];
  fqf_word_t rd_data_d;

  // Read data holds between reads so the consumer may sample late
  always_comb begin
    rd_data_d = port.rd_en ? store[port.rd_addr] : port.rd_data;
  end

  always_ff @(posedge clock) begin
    if (port.wr_en) begin
      store[port.wr_addr] <= port.wr_data;
    end
    port.rd_data <= rd_data_d;
  end
endmodule : fqf_ram

`default_nettype wire

// ==== fqf_pwr.sv ====
// Power-down sequencer with the wake-up wait
`timescale 1ns/1ps
`default_nettype none
`include "fqf_defs.svh"

module fqf_pwr
  import fqf_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic power_down_in,
  output logic run_q
);
  localparam logic [`FQF_CNT_W-1:0] WakeLast = `FQF_CNT_W'(`FQF_WAKE_CYC - 1);

  fqf_pd_state_t state_q;
  fqf_pd_state_t state_d;
  logic [`FQF_CNT_W-1:0] wait_q;
  logic [`FQF_CNT_W-1:0] wait_d;

  always_comb begin
    state_d = state_q;
    wait_d = wait_q;
    case (state_q)
      FQF_PD_RUN: begin
        if (power_down_in) begin
          state_d = FQF_PD_DOWN;
        end
      end
      FQF_PD_DOWN: begin
        if (!power_down_in) begin
          state_d = FQF_PD_WAKE;
          wait_d = '0;
        end
      end
      FQF_PD_WAKE: begin
        if (power_down_in) begin
          state_d = FQF_PD_DOWN;
        end else if (wait_q == WakeLast) begin
          state_d = FQF_PD_RUN;
        end else begin
          wait_d = wait_q + 1'b1;
        end
      end
      default: begin
        state_d = FQF_PD_RUN;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q <= FQF_PD_RUN;
      wait_q <= '0;
      run_q <= 1'b1;
    end else begin
      state_q <= state_d;
      wait_q <= wait_d;
      run_q <= (state_d == FQF_PD_RUN);
    end
  end
endmodule : fqf_pwr

`default_nettype wire

// ==== fqf_top.sv ====
// Four-queue flow-control core: composite flags, echo read enable, power down
`timescale 1ns/1ps
`default_nettype none
`include "fqf_defs.svh"

// Summary of operation
// - Standard mode: composite empty follows new read queue one cycle after select.
// - Fall-through mode: composite output ready follows new read queue after two cycles.
// - Composite full or input ready follows new write queue one cycle after select.
// - Queue may change every cycle; a read queue switch costs two pipeline cycles in fall-through mode, one in standard mode.
// - Standard echo read enable low only for enabled read of non-empty queue.
// - Echo read enable is clocked; echo read clock toggles on every rising clock edge while running.
// - Fall-through echo read enable low whenever a word lands in output register.
// - Data output drives only while read chip select and output enable are low.
// - Read past last word: output ready goes inactive, echo read enable high.
// - Empty clears one cycle after writing an empty queue.
// - Full or input ready releases one cycle after a read frees space.
// - Almost-full updates on clock edges; releases one cycle after reads.
// - Almost-empty releases one cycle after writes pass its offset.
// - Serial offset load and read shift 104 bits at full width, smallest size.
// - Ten-bit input pairs into twenty-bit word: first low, second high.
// - After power down release, operation resumes only after one microsecond.
// - Power down keeps configuration and leaves serial programming inactive.
// - Power down holds every flag; data and echo outputs go high impedance.
// - Latched configuration survives power down and applies on resume.
module fqf_top
  import fqf_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic fall_through_mode,
  input wire logic [1:0] input_width_sel,
  input wire logic [1:0] output_width_sel,
  input wire logic write_chip_select_n,
  input wire logic write_enable_n,
  input wire logic [`FQF_QSEL_W-1:0] write_queue_select,
  input wire logic [`FQF_WORD_W-1:0] data_in,
  input wire logic read_chip_select_n,
  input wire logic read_enable_n,
  input wire logic [`FQF_QSEL_W-1:0] read_queue_select,
  input wire logic output_enable_n,
  input wire logic serial_load_n,
  input wire logic serial_read_n,
  input wire logic serial_in,
  input wire logic power_down_in,
  output logic [`FQF_WORD_W-1:0] data_out,
  output logic data_out_oe,
  output logic composite_empty_n,
  output logic composite_full_n,
  output logic [`FQF_QUEUES-1:0] almost_empty_flag_n,
  output logic [`FQF_QUEUES-1:0] almost_full_flag_n,
  output logic echo_read_enable_n,
  output logic echo_read_clock,
  output logic echo_oe,
  output logic serial_out
);
  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic fqf_ptr_t fill(input fqf_ptr_t wp, input fqf_ptr_t rp);
    return wp - rp;
  endfunction : fill

  function automatic fqf_ofs_t ofs_get(input logic [`FQF_OFS_BITS-1:0] v, input int idx);
    return v[idx*`FQF_OFS_W +: `FQF_OFS_W];
  endfunction : ofs_get

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  localparam fqf_ptr_t Depth = `FQF_PTR_W'(`FQF_DEPTH);
  localparam int PadW = `FQF_WORD_W - 2 * `FQF_HALF_W;

  fqf_mem_if mem_bus ();
  logic run_q;

  fqf_ptr_t [`FQF_QUEUES-1:0] wptr_q, wptr_d, rptr_q, rptr_d;
  logic [`FQF_HALF_W-1:0] hold_q, hold_d;
  logic half_q, half_d;
  logic fetch_q, fetch_d;
  fqf_qsel_t fq_q, fq_d;
  logic oval_q, oval_d;
  fqf_qsel_t oq_q, oq_d;
  fqf_qsel_t rsel_last_q, rsel_last_d;
  logic cfg_fall_through_mode_q, cfg_fall_through_mode_d, cfg_pair_q, cfg_pair_d;
  logic [`FQF_OFS_BITS-1:0] ofs_q, ofs_d;
  fqf_word_t data_d;
  logic oe_d, ce_d, cf_d, echo_read_enable_d, echo_read_clock_d, echo_oe_d, sout_d;
  logic [`FQF_QUEUES-1:0] ae_d, af_d;
  logic wr_go, rd_go, keep, do_fetch, live;
  fqf_ptr_t rd_fill;
  fqf_qsel_t wsel, rsel;

  fqf_ram u_ram (
    .clock(clock),
    .port(mem_bus.mem)
  );

  fqf_pwr u_pwr (
    .clock(clock),
    .sys_rst(sys_rst),
    .power_down_in(power_down_in),
    .run_q(run_q)
  );

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  always_comb begin
    wptr_d = wptr_q;
    rptr_d = rptr_q;
    hold_d = hold_q;
    half_d = half_q;
    oq_d = oq_q;
    data_d = data_out;
    ofs_d = ofs_q;
    sout_d = serial_out;
    ce_d = composite_empty_n;
    cf_d = composite_full_n;
    ae_d = almost_empty_flag_n;
    af_d = almost_full_flag_n;
    wsel = write_queue_select;
    rsel = read_queue_select;
    mem_bus.wr_en = 1'b0;
    mem_bus.wr_addr = {wsel, wptr_q[wsel][`FQF_PTR_W-2:0]};
    mem_bus.wr_data = data_in;
    // Settings are caught only while reset is held, never by power down
    cfg_fall_through_mode_d = sys_rst ? fall_through_mode : cfg_fall_through_mode_q;
    cfg_pair_d = sys_rst ? (input_width_sel == `FQF_BW_X10 && output_width_sel == `FQF_BW_X20)
                         : cfg_pair_q;

    // Write port; full is judged on the registered state so no write is lost
    wr_go = run_q && !write_chip_select_n && !write_enable_n
            && (fill(wptr_q[wsel], rptr_q[wsel]) != Depth);
    if (wr_go) begin
      if (cfg_pair_q && !half_q) begin
        hold_d = data_in[`FQF_HALF_W-1:0];
        half_d = 1'b1;
      end else begin
        mem_bus.wr_en = 1'b1;
        if (cfg_pair_q) begin
          mem_bus.wr_data = {{PadW{1'b0}}, data_in[`FQF_HALF_W-1:0], hold_q};
        end
        wptr_d[wsel] = wptr_q[wsel] + 1'b1;
        half_d = 1'b0;
      end
    end

    // Read port; in fall-through mode the word is peeked and the pointer
    // moves only when the host takes it, so a queue switch loses nothing
    keep = oval_q && (oq_q == rsel);
    rd_go = run_q && !read_chip_select_n && !read_enable_n
            && (cfg_fall_through_mode_q ? keep : (fill(wptr_q[rsel], rptr_q[rsel]) != '0));
    if (rd_go) begin
      rptr_d[rsel] = rptr_q[rsel] + 1'b1;
    end
    keep = keep && !rd_go;
    rd_fill = fill(wptr_q[rsel], rptr_d[rsel]);
    do_fetch = cfg_fall_through_mode_q && run_q && !keep && !(fetch_q && fq_q == rsel)
               && (rd_fill != '0);
    mem_bus.rd_en = cfg_fall_through_mode_q ? do_fetch : rd_go;
    mem_bus.rd_addr = cfg_fall_through_mode_q ? {rsel, rptr_d[rsel][`FQF_PTR_W-2:0]}
                                 : {rsel, rptr_q[rsel][`FQF_PTR_W-2:0]};
    fetch_d = mem_bus.rd_en;
    fq_d = rsel;
    rsel_last_d = rsel;

    // Output register
    oval_d = keep;
    if (fetch_q) begin
      data_d = mem_bus.rd_data;
      oval_d = 1'b1;
      oq_d = fq_q;
    end

    // Echo signals are registered on the read clock
    echo_read_enable_d = cfg_fall_through_mode_q ? !fetch_q : !rd_go;
    echo_read_clock_d = run_q ? !echo_read_clock : echo_read_clock;
    // Drivers release at the very edge that first sees power down
    live = run_q && !power_down_in;
    echo_oe_d = live;
    oe_d = live && !read_chip_select_n && !output_enable_n;

    // Flags freeze while powered down or waking
    if (run_q) begin
      if (cfg_fall_through_mode_q) begin
        // A select change holds the old status one more cycle: two-cycle update
        ce_d = (rsel != rsel_last_q) ? composite_empty_n
                                     : !(oval_d && oq_d == rsel);
        cf_d = (fill(wptr_d[wsel], rptr_d[wsel]) == Depth);
      end else begin
        ce_d = (fill(wptr_d[rsel], rptr_d[rsel]) != '0);
        cf_d = (fill(wptr_d[wsel], rptr_d[wsel]) != Depth);
      end
      for (int q = 0; q < `FQF_QUEUES; q++) begin
        ae_d[q] = ({{(`FQF_OFS_W-`FQF_PTR_W){1'b0}}, fill(wptr_d[q], rptr_d[q])}
                   > ofs_get(ofs_q, 2 * q));
        af_d[q] = ({1'b0, {(`FQF_OFS_W-`FQF_PTR_W){1'b0}}, fill(wptr_d[q], rptr_d[q])}
                   + {1'b0, ofs_get(ofs_q, 2 * q + 1)}
                   < {{(`FQF_OFS_W+1-`FQF_PTR_W){1'b0}}, Depth});
      end
    end

    // Serial offset port; a full pass is the whole offset chain
    if (run_q && !serial_load_n) begin
      ofs_d = {serial_in, ofs_q[`FQF_OFS_BITS-1:1]};
    end else if (run_q && !serial_read_n) begin
      ofs_d = {ofs_q[0], ofs_q[`FQF_OFS_BITS-1:1]};
      sout_d = ofs_q[0];
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    cfg_fall_through_mode_q <= cfg_fall_through_mode_d;
    cfg_pair_q <= cfg_pair_d;
    data_out <= data_d;
    if (sys_rst) begin
      wptr_q <= '0;
      rptr_q <= '0;
      hold_q <= '0;
      half_q <= 1'b0;
      fetch_q <= 1'b0;
      fq_q <= '0;
      oval_q <= 1'b0;
      oq_q <= '0;
      rsel_last_q <= '0;
      ofs_q <= `FQF_OFS_RST;
      serial_out <= 1'b0;
      data_out_oe <= 1'b0;
      composite_empty_n <= fall_through_mode;
      composite_full_n <= !fall_through_mode;
      almost_empty_flag_n <= `FQF_AE_RST;
      almost_full_flag_n <= `FQF_AF_RST;
      echo_read_enable_n <= 1'b1;
      echo_read_clock <= 1'b0;
      echo_oe <= 1'b0;
    end else begin
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
      hold_q <= hold_d;
      half_q <= half_d;
      fetch_q <= fetch_d;
      fq_q <= fq_d;
      oval_q <= oval_d;
      oq_q <= oq_d;
      rsel_last_q <= rsel_last_d;
      ofs_q <= ofs_d;
      serial_out <= sout_d;
      data_out_oe <= oe_d;
      composite_empty_n <= ce_d;
      composite_full_n <= cf_d;
      almost_empty_flag_n <= ae_d;
      almost_full_flag_n <= af_d;
      echo_read_enable_n <= echo_read_enable_d;
      echo_read_clock <= echo_read_clock_d;
      echo_oe <= echo_oe_d;
    end
  end
endmodule : fqf_top

`default_nettype wire

// ==== fqf_sva.sv ====
// Checker of the port-level rules of the four-queue flag core
`timescale 1ns/1ps
`default_nettype none
module fqf_sva (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic fall_through_mode,
  input wire logic read_chip_select_n,
  input wire logic read_enable_n,
  input wire logic [1:0] read_queue_select,
  input wire logic output_enable_n,
  input wire logic power_down_in,
  input wire logic data_out_oe,
  input wire logic composite_empty_n,
  input wire logic composite_full_n,
  input wire logic [3:0] almost_empty_flag_n,
  input wire logic [3:0] almost_full_flag_n,
  input wire logic echo_read_enable_n,
  input wire logic echo_read_clock,
  input wire logic echo_oe
);
  // ----------------------------------------------------------------
  // Wake-up counter
  // ----------------------------------------------------------------
  // Counts edges since power down was released; saturates so it never wraps
  logic [6:0] wake_q;
  logic [6:0] wake_d;
  always_comb begin
    wake_d = wake_q;
    if (power_down_in) wake_d = 7'h01;
    else if (wake_q != 7'h00 && wake_q != 7'h7F) wake_d = wake_q + 7'h01;
  end
  always_ff @(posedge clock) begin
    if (sys_rst) wake_q <= 7'h00;
    else wake_q <= wake_d;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  property p_oe_off; (read_chip_select_n || output_enable_n) |=> !data_out_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("data bus driven while off");
  property p_echo_idle;
    !fall_through_mode && (read_chip_select_n || read_enable_n) |=> echo_read_enable_n;
  endproperty
  a_echo_idle: assert property (p_echo_idle) else $error("echo low without read");
  property p_echo_empty;
    !fall_through_mode && !composite_empty_n && $stable(read_queue_select)
      |=> echo_read_enable_n;
  endproperty
  a_echo_empty: assert property (p_echo_empty) else $error("echo low on empty");
  property p_echo_rd;
    !fall_through_mode && !read_chip_select_n && !read_enable_n && composite_empty_n
      && $stable(read_queue_select) && echo_oe && !power_down_in |=> !echo_read_enable_n;
  endproperty
  a_echo_rd: assert property (p_echo_rd) else $error("echo missed a read");
  property p_echo_read_clock; echo_oe [*3] |-> echo_read_clock != $past(echo_read_clock); endproperty
  a_echo_read_clock: assert property (p_echo_read_clock) else $error("echo clock stalled");
  property p_pd_hiz; power_down_in |=> !data_out_oe && !echo_oe; endproperty
  a_pd_hiz: assert property (p_pd_hiz) else $error("outputs live in power down");
  property p_pd_hold;
    power_down_in [*2] |-> $stable(composite_empty_n) && $stable(composite_full_n)
      && $stable(almost_empty_flag_n) && $stable(almost_full_flag_n);
  endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("flag moved in power down");
  property p_wake_off; wake_q >= 7'h02 && wake_q <= 7'h63 |-> !echo_oe && !data_out_oe; endproperty
  a_wake_off: assert property (p_wake_off) else $error("outputs back too early");
  property p_wake_on; wake_q == 7'h6E |-> echo_oe; endproperty
  a_wake_on: assert property (p_wake_on) else $error("outputs never resumed");
  property p_fall_through_mode_echo;
    fall_through_mode && !echo_read_enable_n |-> !composite_empty_n;
  endproperty
  a_fall_through_mode_echo: assert property (p_fall_through_mode_echo) else $error("echo without word");
endmodule : fqf_sva
`default_nettype wire

// ==== fqf_host.sv ====
// Host model driving the write and read ports of the flag core
`timescale 1ns/1ps
`default_nettype none
module fqf_host
  import fqf_pkg::*;
(
  input wire logic clock,
  output logic write_chip_select_n,
  output logic write_enable_n,
  output var fqf_qsel_t write_queue_select,
  output var fqf_word_t data_in,
  output logic read_chip_select_n,
  output logic read_enable_n,
  output var fqf_qsel_t read_queue_select
);
  // No partial queue reset is ever issued after a select change
  initial begin
    write_chip_select_n = 1'b1;
    write_enable_n = 1'b1;
    write_queue_select = 2'h0;
    data_in = 40'h0;
    read_chip_select_n = 1'b1;
    read_enable_n = 1'b1;
    read_queue_select = 2'h0;
  end
  task automatic wr(input fqf_qsel_t q, input fqf_word_t d);
    @(negedge clock);
    write_chip_select_n = 1'b0;
    write_enable_n = 1'b0;
    write_queue_select = q;
    data_in = d;
  endtask : wr
  // Released data shows the inverse word so a stale value never looks fresh
  task automatic wr_end;
    @(negedge clock);
    write_chip_select_n = 1'b1;
    write_enable_n = 1'b1;
    data_in = ~data_in;
  endtask : wr_end
  task automatic wsel(input fqf_qsel_t q);
    @(negedge clock);
    write_queue_select = q;
  endtask : wsel
  task automatic rsel(input fqf_qsel_t q);
    @(negedge clock);
    read_queue_select = q;
  endtask : rsel
  task automatic rd(input fqf_qsel_t q);
    @(negedge clock);
    read_chip_select_n = 1'b0;
    read_queue_select = q;
    @(negedge clock);
    read_enable_n = 1'b0;
    @(negedge clock);
    read_enable_n = 1'b1;
  endtask : rd
  task automatic rd_off;
    @(negedge clock);
    read_chip_select_n = 1'b1;
  endtask : rd_off
endmodule : fqf_host
`default_nettype wire

// ==== four_queue_flag_echo_powerdown_tb.sv ====
// Self-checking bench for the four-queue flag core
`timescale 1ns/1ps
`default_nettype none
module four_queue_flag_echo_powerdown_tb;
  logic clock, sys_rst, fall_through_mode, output_enable_n, power_down_in;
  logic [1:0] input_width_sel, output_width_sel, write_queue_select, read_queue_select;
  logic write_chip_select_n, write_enable_n, read_chip_select_n, read_enable_n;
  logic serial_load_n, serial_read_n, serial_in, serial_out;
  logic [39:0] data_in, data_out;
  logic data_out_oe, composite_empty_n, composite_full_n, echo_read_enable_n;
  logic echo_read_clock, echo_oe, echo_read_clock_seen;
  logic [3:0] almost_empty_flag_n, almost_full_flag_n;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  fqf_top fqf_top_i (.clock, .sys_rst, .fall_through_mode, .input_width_sel, .output_width_sel,
    .write_chip_select_n, .write_enable_n, .write_queue_select, .data_in, .read_chip_select_n,
    .read_enable_n, .read_queue_select, .output_enable_n, .serial_load_n, .serial_read_n,
    .serial_in, .power_down_in, .data_out, .data_out_oe, .composite_empty_n, .composite_full_n,
    .almost_empty_flag_n, .almost_full_flag_n, .echo_read_enable_n, .echo_read_clock, .echo_oe,
    .serial_out);
  fqf_host fqf_host_i (.clock, .write_chip_select_n, .write_enable_n, .write_queue_select,
    .data_in, .read_chip_select_n, .read_enable_n, .read_queue_select);
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  // Straps are only sampled in reset, so mode changes go through here
  task automatic do_reset(input logic ftm, input logic [1:0] iw, input logic [1:0] ow);
    @(negedge clock);
    sys_rst = 1'b1;
    fall_through_mode = ftm;
    input_width_sel = iw;
    output_width_sel = ow;
    repeat (6) @(negedge clock);
    sys_rst = 1'b0;
  endtask : do_reset
  // Static pins go through one place so each scenario states its own levels
  task automatic pins(input logic oe_n, input logic pd, input logic ld_n, input logic rd_n);
    output_enable_n = oe_n;
    power_down_in = pd;
    serial_load_n = ld_n;
    serial_read_n = rd_n;
  endtask : pins
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      report_and_stop();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    fall_through_mode = 1'b0;
    serial_in = 1'b0;
    pins(1'b0, 1'b0, 1'b1, 1'b1);
    do_reset(1'b0, 2'h0, 2'h0);
    chk("empty_rst", composite_empty_n, 40'h0);
    chk("full_rst", composite_full_n, 40'h1);
    chk("ae_rst", almost_empty_flag_n, 40'h0);
    chk("af_rst", almost_full_flag_n, 40'hF);
    fqf_host_i.rsel(2'h1);
    @(negedge clock);
    chk("empty_q1", composite_empty_n, 40'h0);
    fqf_host_i.wr(2'h1, 40'hA1);
    fqf_host_i.wr(2'h1, 40'hB2);
    chk("empty_clr", composite_empty_n, 40'h1);
    chk("ae_clr", almost_empty_flag_n, 40'h2);
    for (int i = 0; i < 16; i++) fqf_host_i.wr(2'h3, 40'hC00 + 40'(i));
    fqf_host_i.wr_end();
    chk("full_q3", composite_full_n, 40'h0);
    chk("af_q3", almost_full_flag_n, 40'h7);
    fqf_host_i.wsel(2'h0);
    @(negedge clock);
    chk("full_q0", composite_full_n, 40'h1);
    fqf_host_i.wsel(2'h3);
    @(negedge clock);
    chk("full_back", composite_full_n, 40'h0);
    fqf_host_i.rsel(2'h0);
    @(negedge clock);
    chk("empty_q0", composite_empty_n, 40'h0);
    fqf_host_i.rd(2'h1);
    chk("echo_rd", echo_read_enable_n, 40'h0);
    @(negedge clock);
    chk("data_a", data_out, 40'hA1);
    chk("bus_on", data_out_oe, 40'h1);
    pins(1'b1, 1'b0, 1'b1, 1'b1);
    @(negedge clock);
    chk("bus_oe", data_out_oe, 40'h0);
    pins(1'b0, 1'b0, 1'b1, 1'b1);
    fqf_host_i.rd(2'h1);
    chk("echo_rd2", echo_read_enable_n, 40'h0);
    fqf_host_i.rd(2'h1);
    chk("echo_empty", echo_read_enable_n, 40'h1);
    chk("data_b", data_out, 40'hB2);
    fqf_host_i.rd(2'h3);
    chk("full_rel", composite_full_n, 40'h1);
    fqf_host_i.rd_off();
    @(negedge clock);
    chk("bus_off", data_out_oe, 40'h0);
    for (int i = 0; i < 104; i++) begin
      @(negedge clock);
      pins(1'b0, 1'b0, 1'b0, 1'b1);
      serial_in = (i % 3 == 0);
    end
    @(negedge clock);
    pins(1'b0, 1'b0, 1'b1, 1'b0);
    for (int i = 0; i < 104; i++) begin
      @(negedge clock);
      chk("serial", serial_out, 40'(i % 3 == 0));
    end
    pins(1'b0, 1'b0, 1'b1, 1'b1);
    repeat (5) @(negedge clock);
    pins(1'b0, 1'b1, 1'b1, 1'b1);
    repeat (10) @(negedge clock);
    chk("pd_bus", data_out_oe, 40'h0);
    chk("pd_echo", echo_oe, 40'h0);
    pins(1'b0, 1'b0, 1'b1, 1'b1);
    repeat (110) @(negedge clock);
    chk("wake_echo", echo_oe, 40'h1);
    chk("mode_kept", composite_empty_n, 40'h1);
    echo_read_clock_seen = echo_read_clock;
    @(negedge clock);
    chk("echo_read_clock", echo_read_clock, 40'(!echo_read_clock_seen));
    fqf_host_i.wr(2'h0, 40'hC3);
    fqf_host_i.wr_end();
    fqf_host_i.rd(2'h0);
    chk("resume_echo", echo_read_enable_n, 40'h0);
    @(negedge clock);
    chk("resume_data", data_out, 40'hC3);
    fqf_host_i.rd_off();
    do_reset(1'b1, 2'h2, 2'h1);
    chk("or_rst", composite_empty_n, 40'h1);
    chk("ir_rst", composite_full_n, 40'h0);
    fqf_host_i.wr(2'h0, 40'h155);
    fqf_host_i.wr(2'h0, 40'h2AA);
    fqf_host_i.wr_end();
    repeat (2) @(negedge clock);
    chk("echo_land", echo_read_enable_n, 40'h0);
    repeat (4) @(negedge clock);
    chk("or_land", composite_empty_n, 40'h0);
    fqf_host_i.rsel(2'h1);
    @(negedge clock);
    chk("or_hold", composite_empty_n, 40'h0);
    @(negedge clock);
    chk("or_q1", composite_empty_n, 40'h1);
    fqf_host_i.rsel(2'h0);
    repeat (8) @(negedge clock);
    fqf_host_i.rd(2'h0);
    chk("data_pair", data_out, 40'h00000AA955);
    chk("or_none", composite_empty_n, 40'h1);
    chk("echo_none", echo_read_enable_n, 40'h1);
    report_and_stop();
  end
endmodule : four_queue_flag_echo_powerdown_tb
bind fqf_top fqf_sva fqf_sva_i (.clock, .sys_rst, .fall_through_mode, .read_chip_select_n,
  .read_enable_n, .read_queue_select, .output_enable_n, .power_down_in, .data_out_oe,
  .composite_empty_n, .composite_full_n, .almost_empty_flag_n, .almost_full_flag_n,
  .echo_read_enable_n, .echo_read_clock, .echo_oe);
`default_nettype wire
